// ===== hw/bas_supervisor.sv
// Supervisory and control logic of an adaptive boost controller for LED strings.
//
// Summary of operation
// - Only configured outputs steer the boost target.
// - Open or shorted strings leave the loop.
// - Raise target when a monitored output dips.
// - Lower target while all monitored outputs have headroom.
// - Start at 88 percent; adapt once sinks active.
// - Soft overvoltage gates switch, flags, sinks stay.
// - Switching resumes when soft overvoltage clears.
// - Hard overvoltage enters fault recovery, sets flag.
// - Undervoltage starts a 110 ms timer.
// - Expired undervoltage timer: recovery, overcurrent flag.
// - Protection thresholds track the present target.
// - Static sync level selects spread spectrum.
// - Valid sync clock drives external synchronisation.
// - Lost sync clock falls back, uses last level.
// - No spread while externally synchronised.
// - Spread range codes, reset value two.
// - Modulation rate codes, reset value zero.
// - Disable stops boost, sinks, FET; discharges.
// - Discharge lasts 400 ms then shutdown.
// - Discharge pin overvoltage forces hard fault.
// - Light load skips switching cycles.
// - Detect sync clock at start; else internal.
`timescale 1ns/1ps
module bas_supervisor
   import bas_pkg::*;
#(
   parameter int unsigned NOUT          = 4,
   parameter int unsigned UV_TIMEOUT    = UV_TIMEOUT_CYC,
   parameter int unsigned DISCHARGE_LEN = DISCHARGE_CYC,
   parameter int unsigned MON_PERIOD    = MONITOR_PERIOD
) (
   // APB slave
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   // Device enable and string setup
   input  wire logic            enable_pin,
   input  wire logic [NOUT-1:0] string_config_resistor,
   input  wire logic [NOUT-1:0] string_fault,
   input  wire logic            sinks_ready,
   // Analog comparators
   input  wire logic [NOUT-1:0] sink_output_pin_low,
   input  wire logic            soft_overvolt_cmp,
   input  wire logic            hard_overvolt_cmp,
   input  wire logic            boost_undervolt_cmp,
   input  wire logic            discharge_overvolt_cmp,
   input  wire logic            light_load_cmp,
   input  wire logic            boost_clock_select_pin,
   // Power stage controls
   output logic [TW-1:0]        boost_target,
   output logic                 switch_enable,
   output logic                 sinks_enable,
   output logic                 power_fet_on,
   output logic                 discharge_on,
   output logic                 ext_sync_mode,
   output logic                 ext_sync_tick,
   output logic                 spread_enable,
   output logic [6:0]           spread_deviation,
   output logic [10:0]          dither_rate_hz,
   output logic [1:0]           dither_rate_select
);

   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed {
      logic [1:0]      en_sy;
      logic [1:0]      sov_sy;
      logic [1:0]      hov_sy;
      logic [1:0]      uv_sy;
      logic [1:0]      dov_sy;
      logic [1:0]      ll_sy;
      logic [1:0]      clk_sy;
      logic            clk_prev;
      logic [1:0]      rdy_sy;
      logic [NOUT-1:0] low_s1;
      logic [NOUT-1:0] low_s2;
      bas_state_t      state;
      logic [TW-1:0]   target;
      logic [31:0]     tmr;
      logic [31:0]     uv_cnt;
      logic            uv_run;
      logic [15:0]     mon_cnt;
      logic [15:0]     per_cnt;
      logic [2:0]      edges;
      logic            ext;
      logic            tick;
      logic [1:0]      range;
      logic [1:0]      rate;
      logic [2:0]      flags;
      logic [31:0]     rdata;
   } bas_regs_t;

   bas_regs_t r_q;
   bas_regs_t r_d;

   logic            wr_acc;
   logic            rd_acc;
   logic [NOUT-1:0] monitored;
   logic            any_low;
   logic            sync_rise;
   logic            soft_ov;
   logic            hard_ov;
   logic            active;

   always_comb begin
      wr_acc    = psel && penable && pwrite;
      rd_acc    = psel && !penable && !pwrite;
      monitored = r_q.low_s2 & string_config_resistor & ~string_fault;
      any_low   = |monitored;
      sync_rise = r_q.clk_sy[1] && !r_q.clk_prev;
      soft_ov   = r_q.sov_sy[1];
      hard_ov   = r_q.hov_sy[1] || r_q.dov_sy[1];
      active    = (r_q.state == BAS_STARTUP) || (r_q.state == BAS_RUN);
   end

   // ==========================================================================
   // Next state
   // ==========================================================================
   always_comb begin
      r_d          = r_q;
      r_d.en_sy    = {r_q.en_sy[0], enable_pin};
      r_d.sov_sy   = {r_q.sov_sy[0], soft_overvolt_cmp};
      r_d.hov_sy   = {r_q.hov_sy[0], hard_overvolt_cmp};
      r_d.uv_sy    = {r_q.uv_sy[0], boost_undervolt_cmp};
      r_d.dov_sy   = {r_q.dov_sy[0], discharge_overvolt_cmp};
      r_d.ll_sy    = {r_q.ll_sy[0], light_load_cmp};
      r_d.clk_sy   = {r_q.clk_sy[0], boost_clock_select_pin};
      r_d.clk_prev = r_q.clk_sy[1];
      r_d.rdy_sy   = {r_q.rdy_sy[0], sinks_ready};
      r_d.low_s1   = sink_output_pin_low;
      r_d.low_s2   = r_q.low_s1;
      r_d.tick     = 1'b0;

      // Sync clock detector; a period out of range or a stall drops the lock.
      if (sync_rise) begin
         r_d.per_cnt = 16'h0000;
         if (r_q.per_cnt + 16'h0001 >= 16'(SYNC_MIN_PER_CYC)) begin
            if (r_q.edges != 3'(SYNC_EDGES_LOCK)) begin
               r_d.edges = r_q.edges + 3'h1;
            end
         end else begin
            r_d.edges = 3'h0;
         end
         r_d.tick = r_q.ext;
      end else if (r_q.per_cnt >= 16'(SYNC_MAX_PER_CYC)) begin
         r_d.edges = 3'h0;
      end else begin
         r_d.per_cnt = r_q.per_cnt + 16'h0001;
      end
      r_d.ext = (r_q.edges == 3'(SYNC_EDGES_LOCK));

      // Undervoltage timeout runs only while the stage is active (startup or run).
      if (active && r_q.uv_sy[1]) begin
         r_d.uv_run = 1'b1;
         r_d.uv_cnt = r_q.uv_run ? r_q.uv_cnt + 32'h1 : 32'h0;
      end else begin
         r_d.uv_run = 1'b0;
         r_d.uv_cnt = 32'h0;
      end

      // Status flags; a clear write loses to a new event.
      if (wr_acc && paddr == ADDR_STATUS) begin
         r_d.flags = r_q.flags & ~pwdata[2:0];
      end
      if (active && soft_ov) begin
         r_d.flags[ST_SOFT_OV] = 1'b1;
      end

      unique case (r_q.state)
         BAS_OFF: begin
            r_d.target = TARGET_INIT;
            r_d.tmr    = 32'h0;
            if (r_q.en_sy[1]) begin
               r_d.state = BAS_STARTUP;
            end
         end
         BAS_STARTUP: begin
            r_d.target = TARGET_INIT;
            if (r_q.rdy_sy[1]) begin
               r_d.state   = BAS_RUN;
               r_d.mon_cnt = 16'h0000;
            end
         end
         BAS_RUN: begin
            if (r_q.mon_cnt >= 16'(MON_PERIOD - 1)) begin
               r_d.mon_cnt = 16'h0000;
               if (any_low) begin
                  r_d.target = (r_q.target > TARGET_MAX - TARGET_STEP) ?
                               TARGET_MAX : r_q.target + TARGET_STEP;
               end else begin
                  r_d.target = (r_q.target < TARGET_STEP) ?
                               '0 : r_q.target - TARGET_STEP;
               end
            end else begin
               r_d.mon_cnt = r_q.mon_cnt + 16'h0001;
            end
         end
         BAS_FAULT: begin
            r_d.target = TARGET_INIT;
            if (!hard_ov && !r_q.uv_sy[1]) begin
               r_d.state = BAS_STARTUP;
            end
         end
         BAS_DISCHARGE: begin
            r_d.tmr = r_q.tmr + 32'h1;
            if (r_q.tmr >= DISCHARGE_LEN - 1) begin
               r_d.state = BAS_OFF;
            end
         end
      endcase

      if (active && hard_ov) begin
         r_d.state                = BAS_FAULT;
         r_d.flags[ST_HARD_OV]    = 1'b1;
      end else if (active && r_q.uv_run && r_q.uv_cnt >= UV_TIMEOUT - 1) begin
         r_d.state                = BAS_FAULT;
         r_d.flags[ST_OVERCURRENT] = 1'b1;
      end
      if (r_q.dov_sy[1]) begin
         r_d.flags[ST_HARD_OV] = 1'b1;
      end
      if (!r_q.en_sy[1] && r_q.state != BAS_OFF && r_q.state != BAS_DISCHARGE) begin
         r_d.state = BAS_DISCHARGE;
         r_d.tmr   = 32'h0;
      end

      // Control register.
      if (wr_acc && paddr == ADDR_CTRL) begin
         r_d.range = pwdata[CTRL_RANGE_LSB +: 2];
         r_d.rate  = pwdata[CTRL_RATE_LSB +: 2];
      end

      // Read data is captured in setup so it is stable in the access phase.
      if (rd_acc) begin
         r_d.rdata = 32'h0;
         unique case (paddr)
            ADDR_CTRL: begin
               r_d.rdata[CTRL_RANGE_LSB +: 2] = r_q.range;
               r_d.rdata[CTRL_RATE_LSB +: 2]  = r_q.rate;
            end
            ADDR_STATUS: begin
               r_d.rdata[2:0]            = r_q.flags;
               r_d.rdata[ST_EXT_SYNC]    = r_q.ext;
               r_d.rdata[ST_SPREAD_ON]   = spread_enable;
               r_d.rdata[ST_FAULT_REC]   = (r_q.state == BAS_FAULT);
               r_d.rdata[ST_SKIP]        = r_q.ll_sy[1];
            end
            ADDR_TARGET: begin
               r_d.rdata[TW-1:0] = r_q.target;
            end
            default: begin
               r_d.rdata = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q       <= '0;
         r_q.state <= BAS_OFF;
         r_q.target <= TARGET_INIT;
         r_q.range <= RANGE_RESET;
         r_q.rate  <= RATE_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   always_comb begin
      pready             = 1'b1;
      prdata             = r_q.rdata;
      pslverr            = psel && penable && !(paddr == ADDR_CTRL || paddr == ADDR_STATUS ||
                                                paddr == ADDR_TARGET);
      // Thresholds are offsets from this target in the analog stage.
      boost_target       = r_q.target;
      switch_enable      = active && !soft_ov && !r_q.ll_sy[1];
      sinks_enable       = (r_q.state == BAS_RUN);
      power_fet_on       = active;
      discharge_on       = (r_q.state == BAS_DISCHARGE);
      ext_sync_mode      = r_q.ext;
      ext_sync_tick      = r_q.tick;
      spread_enable      = !r_q.ext && r_q.clk_sy[1];
      spread_deviation   = SPREAD_DEV[r_q.range];
      dither_rate_hz     = DITHER_HZ[r_q.rate];
      dither_rate_select = r_q.rate;
   end

endmodule // bas_supervisor

// ===== hw/bas_pkg.sv
// Package with register map, field layouts and timing constants of the boost supervisor.
package bas_pkg;

   // ==========================================================================
   // Clock and timing
   // ==========================================================================
   localparam int unsigned CLK_HZ            = 40_000_000;
   localparam int unsigned UV_TIMEOUT_MS     = 110;
   localparam int unsigned DISCHARGE_MS      = 400;
   localparam int unsigned UV_TIMEOUT_CYC    = (CLK_HZ / 1000) * UV_TIMEOUT_MS;
   localparam int unsigned DISCHARGE_CYC     = (CLK_HZ / 1000) * DISCHARGE_MS;
   localparam int unsigned SYNC_MIN_KHZ      = 100;
   localparam int unsigned SYNC_MAX_KHZ      = 2222;
   // Longest legal sync period (floor) and shortest (ceiling), in cycles.
   localparam int unsigned SYNC_MAX_PER_CYC  = CLK_HZ / (SYNC_MIN_KHZ * 1000);
   localparam int unsigned SYNC_MIN_PER_CYC  = (CLK_HZ + SYNC_MAX_KHZ * 1000 - 1) / (SYNC_MAX_KHZ * 1000);
   localparam int unsigned MONITOR_PERIOD    = 4000;
   localparam int unsigned SYNC_EDGES_LOCK   = 4;

   // ==========================================================================
   // Target scale: 0 is minimum boost level, TARGET_MAX is maximum
   // ==========================================================================
   localparam int unsigned TW                = 10;
   localparam logic [TW-1:0] TARGET_MAX      = 10'h3ff;
   // Initial level at 88 percent of the range.
   localparam logic [TW-1:0] TARGET_INIT     = 10'h384;
   localparam logic [TW-1:0] TARGET_STEP     = 10'h004;

   // ==========================================================================
   // Register offsets
   // ==========================================================================
   localparam logic [11:0] ADDR_CTRL         = 12'h000;
   localparam logic [11:0] ADDR_STATUS       = 12'h004;
   localparam logic [11:0] ADDR_TARGET       = 12'h008;
   localparam logic [11:0] ADDR_MASK         = 12'h00c;

   // CTRL fields.
   localparam int unsigned CTRL_RANGE_LSB    = 0;
   localparam int unsigned CTRL_RATE_LSB     = 2;
   localparam logic [1:0] RANGE_RESET        = 2'h2;
   localparam logic [1:0] RATE_RESET         = 2'h0;

   // STATUS bits; flags clear by writing one.
   localparam int unsigned ST_SOFT_OV        = 0;
   localparam int unsigned ST_HARD_OV        = 1;
   localparam int unsigned ST_OVERCURRENT    = 2;
   localparam int unsigned ST_EXT_SYNC       = 8;
   localparam int unsigned ST_SPREAD_ON      = 9;
   localparam int unsigned ST_FAULT_REC      = 10;
   localparam int unsigned ST_SKIP           = 11;

   // Deviation in tenths of a percent and modulation rate in Hz per code.
   localparam logic [6:0]  SPREAD_DEV [4]    = '{7'd33, 7'd43, 7'd53, 7'd72};
   localparam logic [10:0] DITHER_HZ [4]     = '{11'd200, 11'd500, 11'd800, 11'd1200};

   typedef enum logic [4:0] {
      BAS_OFF       = 5'b00001,
      BAS_STARTUP   = 5'b00010,
      BAS_RUN       = 5'b00100,
      BAS_FAULT     = 5'b01000,
      BAS_DISCHARGE = 5'b10000
   } bas_state_t;

endpackage

// ===== bench/bas_supervisor_asserts.sv
// Assertion checker for the boost supervisor ports.
`timescale 1ns/1ps
module bas_supervisor_asserts
   import bas_pkg::*;
#(
   parameter int unsigned UV_TIMEOUT    = 200,
   parameter int unsigned DISCHARGE_LEN = 300
) (
   // Clock, reset and inputs
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          enable_pin,
   input wire logic          soft_overvolt_cmp,
   input wire logic          hard_overvolt_cmp,
   input wire logic          boost_undervolt_cmp,
   input wire logic          discharge_overvolt_cmp,
   input wire logic          light_load_cmp,
   // Outputs
   input wire logic [TW-1:0] boost_target,
   input wire logic          switch_enable,
   input wire logic          sinks_enable,
   input wire logic          power_fet_on,
   input wire logic          discharge_on,
   input wire logic          ext_sync_mode,
   input wire logic          spread_enable,
   input wire logic [10:0]   dither_rate_hz,
   input wire logic [1:0]    dither_rate_select
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [31:0] uv_run_q;
   logic [31:0] dis_run_q;
   // Runs of consecutive cycles with undervoltage and with discharge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_run_q  <= '0;
         dis_run_q <= '0;
      end else begin
         uv_run_q  <= boost_undervolt_cmp ? uv_run_q + 32'h1 : '0;
         dis_run_q <= discharge_on ? dis_run_q + 32'h1 : '0;
      end
   end
   sequence s_soft_only;
      soft_overvolt_cmp && !hard_overvolt_cmp && !boost_undervolt_cmp && !discharge_overvolt_cmp && enable_pin;
   endsequence
   sequence s_clear;
      !soft_overvolt_cmp && !light_load_cmp;
   endsequence
   a_soft_gate: assert property (soft_overvolt_cmp [*5] |-> !switch_enable)
      else $error("switch runs during soft overvoltage");
   a_soft_sinks: assert property (s_soft_only [*5] ##0 sinks_enable |=> sinks_enable)
      else $error("sinks dropped on soft overvoltage");
   a_soft_resume: assert property (s_clear [*5] ##0 sinks_enable |-> switch_enable)
      else $error("switching did not resume");
   a_hard_fault: assert property (hard_overvolt_cmp [*6] |-> !sinks_enable && !switch_enable)
      else $error("no recovery on hard overvoltage");
   a_dis_fault: assert property (discharge_overvolt_cmp [*6] |-> !sinks_enable)
      else $error("no recovery on discharge overvoltage");
   a_uv_expire: assert property (uv_run_q > UV_TIMEOUT + 6 |-> !sinks_enable)
      else $error("undervoltage timer never expired");
   a_disable_stop: assert property (!enable_pin [*5] |->
      !sinks_enable && !switch_enable && !power_fet_on)
      else $error("stage still active while disabled");
   a_dis_len: assert property (dis_run_q <= DISCHARGE_LEN)
      else $error("discharge lasts too long");
   a_no_spread_ext: assert property (ext_sync_mode |-> !spread_enable)
      else $error("spread active with external clock");
   a_rate_map: assert property ($stable(dither_rate_select) |->
      dither_rate_hz == DITHER_HZ[dither_rate_select])
      else $error("modulation rate mismatch");
   a_step_size: assert property (sinks_enable && $past(sinks_enable) && $changed(boost_target)
      |-> (boost_target - $past(boost_target)) inside {10'h004, 10'h3fc} || boost_target == TARGET_MAX)
      else $error("target step wrong");
endmodule // bas_supervisor_asserts

bind bas_supervisor bas_supervisor_asserts #(.UV_TIMEOUT(UV_TIMEOUT), .DISCHARGE_LEN(DISCHARGE_LEN))
   bas_supervisor_asserts_inst (.pclk(pclk), .presetn(presetn), .enable_pin(enable_pin),
   .soft_overvolt_cmp(soft_overvolt_cmp), .hard_overvolt_cmp(hard_overvolt_cmp),
   .boost_undervolt_cmp(boost_undervolt_cmp), .discharge_overvolt_cmp(discharge_overvolt_cmp),
   .light_load_cmp(light_load_cmp), .boost_target(boost_target), .switch_enable(switch_enable),
   .sinks_enable(sinks_enable), .power_fet_on(power_fet_on), .discharge_on(discharge_on),
   .ext_sync_mode(ext_sync_mode), .spread_enable(spread_enable), .dither_rate_hz(dither_rate_hz),
   .dither_rate_select(dither_rate_select));

// ===== bench/bas_stage_model.sv
// Behavioural model of the analog power stage and its comparators.
`timescale 1ns/1ps
module bas_stage_model
   import bas_pkg::*;
#(
   parameter int unsigned NOUT = 4,
   parameter int unsigned LAG  = 3
) (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // From the supervisor
   input  wire logic [TW-1:0]      boost_target,
   input  wire logic               sinks_enable,
   input  wire logic               power_fet_on,
   // Scenario setup
   input  wire logic [NOUT*TW-1:0] need,
   input  wire logic [4:0]         inject,
   // To the supervisor
   output logic [NOUT-1:0]         sink_output_pin_low,
   output logic [4:0]              cmp,
   output logic                    sinks_ready
);
   logic [LAG:0] fet_q;
   // Sinks report ready only after the boost has had time to ramp.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fet_q <= '0;
         cmp   <= '0;
      end else begin
         fet_q <= {fet_q[LAG-1:0], power_fet_on};
         cmp   <= inject;
      end
   end
   assign sinks_ready = fet_q[LAG];
   // A pin lacks headroom while the boost target does not exceed its string need.
   always_comb begin
      for (int i = 0; i < NOUT; i++) begin
         sink_output_pin_low[i] = sinks_enable && (boost_target <= need[i*TW +: TW]);
      end
   end
endmodule // bas_stage_model

// ===== bench/tb_top.sv
// Self-checking testbench of the boost supervisor.
`timescale 1ns/1ps
module tb_top;
   import bas_pkg::*;
   localparam int UVT = 200;
   localparam int DSL = 300;
   localparam int MON = 16;
   logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0]   paddr = '0;
   logic [31:0]   pwdata = '0, prdata, rdata;
   logic          pready, pslverr, rerr, enable_pin = 0, sync_pin = 0;
   logic [3:0]    cfg = 4'h3, fault = '0, pin_low;
   logic [39:0]   need = '0;
   logic [4:0]    inject = '0, cmp;
   logic          sinks_ready, switch_enable, sinks_enable, power_fet_on, discharge_on;
   logic          ext_sync_mode, ext_sync_tick, spread_enable;
   logic [TW-1:0] boost_target;
   logic [6:0]    spread_deviation;
   logic [10:0]   dither_rate_hz;
   logic [1:0]    dither_rate_select;
   int            error_cnt = 0, checks_done = 0, cyc = 0, k;

   bas_supervisor #(.NOUT(4), .UV_TIMEOUT(UVT), .DISCHARGE_LEN(DSL), .MON_PERIOD(MON)) bas_supervisor_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
      .string_config_resistor(cfg), .string_fault(fault), .sinks_ready(sinks_ready),
      .sink_output_pin_low(pin_low), .soft_overvolt_cmp(cmp[0]), .hard_overvolt_cmp(cmp[1]),
      .boost_undervolt_cmp(cmp[2]), .discharge_overvolt_cmp(cmp[3]), .light_load_cmp(cmp[4]),
      .boost_clock_select_pin(sync_pin), .boost_target(boost_target), .switch_enable(switch_enable),
      .sinks_enable(sinks_enable), .power_fet_on(power_fet_on), .discharge_on(discharge_on),
      .ext_sync_mode(ext_sync_mode), .ext_sync_tick(ext_sync_tick), .spread_enable(spread_enable),
      .spread_deviation(spread_deviation), .dither_rate_hz(dither_rate_hz),
      .dither_rate_select(dither_rate_select));
   bas_stage_model #(.NOUT(4), .LAG(3)) bas_stage_model_inst (.pclk(pclk), .presetn(presetn),
      .boost_target(boost_target), .sinks_enable(sinks_enable), .power_fet_on(power_fet_on), .need(need),
      .inject(inject), .sink_output_pin_low(pin_low), .cmp(cmp), .sinks_ready(sinks_ready));

   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("unexpected at %0t: timeout", $time);
         stop_test;
      end
   end

   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic stop_test;
      $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic wait_run;
      for (k = 0; k < 400 && sinks_enable !== 1'b1; k++) @(posedge pclk);
      chk(sinks_enable, 1, "run");
   endtask

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_regs;
      logic [6:0]  dev [4] = '{7'd33, 7'd43, 7'd53, 7'd72};
      logic [10:0] hz [4]  = '{11'd200, 11'd500, 11'd800, 11'd1200};
      apb(0, ADDR_CTRL, '0);
      chk(rdata[3:0], 32'h2, "ctrl reset");
      for (int c = 0; c < 4; c++) begin
         apb(1, ADDR_CTRL, {28'h0, c[1:0], c[1:0]});
         tick(2);
         chk(spread_deviation, dev[c], "range");
         chk(dither_rate_hz, hz[c], "rate");
         chk(dither_rate_select, c, "rate code");
      end
      apb(0, ADDR_MASK, '0);
      chk({rerr, rdata[30:0]}, 32'h80000000, "unmapped");
      $display("done regs");
   endtask
   task automatic t_adapt;
      need       <= {10'h3ff, 10'h3ff, 10'h300, 10'h300};
      enable_pin <= 1'b1;
      tick(4);
      chk(boost_target, TARGET_INIT, "init");
      chk(sinks_enable, 0, "early sinks");
      wait_run;
      tick(MON * 4);
      chk(boost_target < TARGET_INIT, 1, "lowering");
      tick(MON * 40);
      chk(boost_target inside {10'h300, 10'h304}, 1, "settled");
      fault      <= 4'h1;
      need[9:0]  <= 10'h3ff;
      tick(MON * 10);
      chk(boost_target inside {10'h300, 10'h304}, 1, "faulted pin");
      need[19:10] <= 10'h3ff;
      tick(MON * 80);
      chk(boost_target, TARGET_MAX, "clamp");
      $display("done adapt");
   endtask
   task automatic t_soft;
      inject <= 5'h01;
      tick(8);
      chk(switch_enable, 0, "soft gate");
      chk(sinks_enable, 1, "soft sinks");
      apb(0, ADDR_STATUS, '0);
      chk(rdata[ST_SOFT_OV], 1, "soft flag");
      // Light load is held for 32 cycles, then switching must come back.
      inject <= 5'h10;
      k = 0;
      for (int n = 0; n < 64; n++) begin
         @(posedge pclk);
         k += !switch_enable;
         if (n == 31) inject <= '0;
      end
      chk(k > 32 && k < 64, 1, "skipping");
      tick(8);
      chk(switch_enable, 1, "resume");
      $display("done soft");
   endtask
   task automatic t_fault(input logic [4:0] src, input int len, input logic [2:0] flags);
      inject <= src;
      tick(len);
      // A zero flag set means the event must not reach fault recovery.
      chk(sinks_enable, flags == 3'h0, "fault sinks");
      apb(0, ADDR_STATUS, '0);
      chk({rdata[ST_FAULT_REC], rdata[2:1]}, {flags != 3'h0, flags[2:1]}, "fault flags");
      inject <= '0;
      tick(8);
      apb(1, ADDR_STATUS, 32'h7);
      wait_run;
      apb(0, ADDR_STATUS, '0);
      chk(rdata[2:0], 0, "cleared");
      $display("done fault");
   endtask
   task automatic t_sync;
      sync_pin <= 1'b1;
      tick(8);
      chk(spread_enable, 1, "static high");
      sync_pin <= 1'b0;
      tick(8);
      chk(spread_enable, 0, "static low");
      // A 1 MHz clock of 40 cycles a period lies inside the legal band; the last four periods are locked.
      k = 0;
      for (int p = 0; p < 12; p++) begin
         sync_pin <= 1'b1;
         repeat (20) begin
            @(posedge pclk);
            if (p >= 8) k += ext_sync_tick;
         end
         sync_pin <= 1'b0;
         repeat (20) begin
            @(posedge pclk);
            if (p >= 8) k += ext_sync_tick;
         end
      end
      chk({ext_sync_mode, spread_enable}, 2'b10, "ext mode");
      chk(k, 4, "sync ticks");
      sync_pin <= 1'b1;
      tick(450);
      chk({ext_sync_mode, spread_enable}, 2'b01, "clock lost");
      $display("done sync");
   endtask
   task automatic t_off;
      enable_pin <= 1'b0;
      for (k = 0; k < 10 && discharge_on !== 1'b1; k++) @(posedge pclk);
      chk({discharge_on, power_fet_on, sinks_enable, switch_enable}, 4'h8, "disable");
      for (k = 0; k < DSL + 40 && discharge_on === 1'b1; k++) @(posedge pclk);
      chk(k >= DSL - 1 && k <= DSL + 1, 1, "discharge length");
      $display("done off");
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_adapt;
      t_soft;
      t_fault(5'h02, 8, 3'h2);
      t_fault(5'h08, 8, 3'h2);
      t_fault(5'h04, UVT / 2, 3'h0);
      t_fault(5'h04, UVT + 12, 3'h4);
      t_sync;
      t_off;
      stop_test;
   end
endmodule // tb_top
